/* File: hw/tce_device.sv */
`timescale 1ns/1ps
`include "tce_defs.svh"
module tce_device
  import tce_pkg::*;
#(
  parameter int PROC_CYC = `TCE_PROC_CYC,
  parameter int USABLE   = `TCE_USABLE_PINS
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         link_clk,
  input  wire logic                         external_reset_pin,
  tce_if.dev                                bus,
  input  wire logic [6:0]                   cfg_addr,
  output logic      [7:0]                   rx_data,
  output logic                              rx_valid,
  output logic                              rx_first,
  input  wire logic [7:0]                   tx_data,
  output logic                              tx_taken,
  input  wire logic [`TCE_PIN_COUNT-1:0]    pin_sel,
  input  wire logic [`TCE_PIN_COUNT-1:0]    pin_sense,
  input  wire logic [`TCE_PIN_COUNT-1:0]    gpio_dir,
  input  wire logic [`TCE_PIN_COUNT-1:0]    gpio_out,
  output logic      [`TCE_PIN_COUNT-1:0]    gpio_in,
  output logic      [`TCE_PIN_COUNT-1:0]    sense_in,
  input  wire logic [`TCE_PORT_PINS-1:0]    general_port_zero_i,
  output logic      [`TCE_PORT_PINS-1:0]    general_port_zero_o,
  output logic      [`TCE_PORT_PINS-1:0]    general_port_zero_oe_n,
  input  wire logic [`TCE_PORT_PINS-1:0]    general_port_one_i,
  output logic      [`TCE_PORT_PINS-1:0]    general_port_one_o,
  output logic      [`TCE_PORT_PINS-1:0]    general_port_one_oe_n
);
  localparam int NP = `TCE_PIN_COUNT;
  localparam int CW = $clog2(PROC_CYC + 1);

  // reset pin
  // either reset clears both domains; release is synchronised per domain
  logic rst_any;
  logic rc1_reg, rc2_reg, rl1_reg, rl2_reg;
  assign rst_any = rst | external_reset_pin;

  always_ff @(posedge clk or posedge rst_any) begin
    if (rst_any) begin
      rc1_reg <= 1'b1;
      rc2_reg <= 1'b1;
    end else begin
      rc1_reg <= 1'b0;
      rc2_reg <= rc1_reg;
    end
  end

  always_ff @(posedge link_clk or posedge rst_any) begin
    if (rst_any) begin
      rl1_reg <= 1'b1;
      rl2_reg <= 1'b1;
    end else begin
      rl1_reg <= 1'b0;
      rl2_reg <= rl1_reg;
    end
  end

  // ---------------- link side, on the link clock ----------------
  tce_lnk_e  st_reg, st_next;
  tce_kind_e kind_reg, kind_next;
  logic [7:0] sh_reg, sh_next, hold_reg, hold_next;
  logic [3:0] cnt_reg, cnt_next;
  logic       rd_reg, rd_next, req_reg, req_next;
  logic       sclo_reg, sclo_next, sdao_reg, sdao_next;
  logic       ackseen_reg, ackseen_next;
  logic       scl1_reg, scl2_reg, scld_reg, sda1_reg, sda2_reg, sdad_reg;
  logic       ack1_reg, ack2_reg;
  // core side reply, read by the link only after its toggle is seen
  logic       acktgl_reg, acktgl_next, repack_reg, repack_next;
  logic [7:0] repdat_reg, repdat_next;
  logic       start, stop, rise, fall;

  assign start = scl2_reg & scld_reg & sdad_reg & ~sda2_reg;
  assign stop  = scl2_reg & scld_reg & ~sdad_reg & sda2_reg;
  assign rise  = scl2_reg & ~scld_reg;
  assign fall  = ~scl2_reg & scld_reg;

  // link state machine
  always_comb begin
    st_next      = st_reg;
    kind_next    = kind_reg;
    sh_next      = sh_reg;
    hold_next    = hold_reg;
    cnt_next     = cnt_reg;
    rd_next      = rd_reg;
    req_next     = req_reg;
    sclo_next    = sclo_reg;
    sdao_next    = sdao_reg;
    ackseen_next = ackseen_reg;
    if (stop) begin
      st_next   = L_IDLE;
      sclo_next = 1'b1;
      sdao_next = 1'b1;
    end else if (start) begin
      // first byte after start is the address
      st_next   = L_RX;
      kind_next = TCE_K_ADDR;
      cnt_next  = 4'h0;
      sdao_next = 1'b1;
    end else begin
      case (st_reg)
        L_RX: begin
          if (rise && cnt_reg != 4'h8) begin
            sh_next  = {sh_reg[6:0], sda2_reg};
            cnt_next = cnt_reg + 4'h1;
          end else if (fall && cnt_reg == 4'h8) begin
            sclo_next = 1'b0;
            hold_next = sh_reg;
            req_next  = ~req_reg;
            st_next   = L_WAIT;
          end
        end
        L_WAIT: begin
          if (ack2_reg != ackseen_reg) begin
            ackseen_next = ack2_reg;
            sclo_next    = 1'b1;   // release only once the core answered
            sh_next      = repdat_reg;
            cnt_next     = 4'h0;
            if (kind_reg == TCE_K_RD) begin
              sdao_next = repdat_reg[7];
              st_next   = L_TX;
            end else if (repack_reg) begin
              sdao_next = 1'b0;
              st_next   = L_ACK;
              if (kind_reg == TCE_K_ADDR) begin
                rd_next = hold_reg[0];
              end
            end else begin
              st_next = L_SKIP;
            end
          end
        end
        L_ACK: begin
          if (fall) begin
            cnt_next = 4'h0;
            if (rd_reg) begin
              kind_next = TCE_K_RD;
              sdao_next = sh_reg[7];
              st_next   = L_TX;
            end else begin
              kind_next = TCE_K_WR;
              sdao_next = 1'b1;
              st_next   = L_RX;
            end
          end
        end
        L_TX: begin
          if (fall) begin
            if (cnt_reg == 4'h7) begin
              sdao_next = 1'b1;
              st_next   = L_MACK;
            end else begin
              sh_next   = {sh_reg[6:0], 1'b0};
              sdao_next = sh_reg[6];
              cnt_next  = cnt_reg + 4'h1;
            end
          end
        end
        L_MACK: begin
          if (rise) begin
            cnt_next = {3'h0, ~sda2_reg};
          end else if (fall) begin
            if (cnt_reg[0]) begin
              // hold while next byte is fetched
              sclo_next = 1'b0;
              req_next  = ~req_reg;
              st_next   = L_WAIT;
            end else begin
              st_next = L_SKIP;  // master refused: wait for stop
            end
          end
        end
        default: begin
          st_next = st_reg;
        end
      endcase
    end
  end

  // link registers and pin synchronisers
  always_ff @(posedge link_clk or posedge rl2_reg) begin
    if (rl2_reg) begin
      st_reg      <= L_IDLE;
      kind_reg    <= TCE_K_ADDR;
      sh_reg      <= 8'h00;
      hold_reg    <= 8'h00;
      cnt_reg     <= 4'h0;
      rd_reg      <= 1'b0;
      req_reg     <= 1'b0;
      sclo_reg    <= 1'b1;
      sdao_reg    <= 1'b1;
      ackseen_reg <= 1'b0;
      scl1_reg    <= 1'b1;
      scl2_reg    <= 1'b1;
      scld_reg    <= 1'b1;
      sda1_reg    <= 1'b1;
      sda2_reg    <= 1'b1;
      sdad_reg    <= 1'b1;
      ack1_reg    <= 1'b0;
      ack2_reg    <= 1'b0;
    end else begin
      st_reg      <= st_next;
      kind_reg    <= kind_next;
      sh_reg      <= sh_next;
      hold_reg    <= hold_next;
      cnt_reg     <= cnt_next;
      rd_reg      <= rd_next;
      req_reg     <= req_next;
      sclo_reg    <= sclo_next;
      sdao_reg    <= sdao_next;
      ackseen_reg <= ackseen_next;
      scl1_reg    <= bus.scl;
      scl2_reg    <= scl1_reg;
      scld_reg    <= scl2_reg;
      sda1_reg    <= bus.sda;
      sda2_reg    <= sda1_reg;
      sdad_reg    <= sda2_reg;
      ack1_reg    <= acktgl_reg;
      ack2_reg    <= ack1_reg;
    end
  end

  assign bus.dev_scl_o    = 1'b0;
  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_scl_oe_n = sclo_reg;
  assign bus.dev_sda_oe_n = sdao_reg;

  // ---------------- core side, on clk ----------------
  logic [CW-1:0] pc_reg, pc_next;
  logic          rq1_reg, rq2_reg, rqseen_reg, rqseen_next;
  logic          first_reg, first_next;
  logic [7:0]    rxd_reg, rxd_next;
  logic          rxv_reg, rxv_next, rxf_reg, rxf_next, txt_reg, txt_next;
  logic [6:0]    addr_reg;

  // byte processing; hold_reg and kind_reg stay still while the clock is held
  always_comb begin
    pc_next     = pc_reg;
    rqseen_next = rqseen_reg;
    acktgl_next = acktgl_reg;
    repack_next = repack_reg;
    repdat_next = repdat_reg;
    first_next  = first_reg;
    rxd_next    = rxd_reg;
    rxf_next    = rxf_reg;
    rxv_next    = 1'b0;
    txt_next    = 1'b0;
    if (pc_reg != '0) begin
      pc_next = pc_reg - CW'(1);
      if (pc_reg == CW'(1)) begin
        acktgl_next = ~acktgl_reg;
        repack_next = 1'b1;
        case (kind_reg)
          TCE_K_ADDR: begin
            repack_next = (hold_reg[7:1] == addr_reg);
            first_next  = 1'b1;
            if (hold_reg[7:1] == addr_reg && hold_reg[0]) begin
              repdat_next = tx_data;
              txt_next    = 1'b1;
            end
          end
          TCE_K_WR: begin
            rxd_next   = hold_reg;
            rxf_next   = first_reg;
            rxv_next   = 1'b1;
            first_next = 1'b0;
          end
          default: begin
            repdat_next = tx_data;
            txt_next    = 1'b1;
          end
        endcase
      end
    end else if (rq2_reg != rqseen_reg) begin
      rqseen_next = rq2_reg;
      pc_next     = CW'(PROC_CYC);
    end
  end

  always_ff @(posedge clk or posedge rc2_reg) begin
    if (rc2_reg) begin
      pc_reg     <= '0;
      rq1_reg    <= 1'b0;
      rq2_reg    <= 1'b0;
      rqseen_reg <= 1'b0;
      acktgl_reg <= 1'b0;
      repack_reg <= 1'b0;
      repdat_reg <= 8'hFF;
      first_reg  <= 1'b0;
      rxd_reg    <= 8'h00;
      rxv_reg    <= 1'b0;
      rxf_reg    <= 1'b0;
      txt_reg    <= 1'b0;
      addr_reg   <= 7'h00;
    end else begin
      pc_reg     <= pc_next;
      rq1_reg    <= req_reg;
      rq2_reg    <= rq1_reg;
      rqseen_reg <= rqseen_next;
      acktgl_reg <= acktgl_next;
      repack_reg <= repack_next;
      repdat_reg <= repdat_next;
      first_reg  <= first_next;
      rxd_reg    <= rxd_next;
      rxv_reg    <= rxv_next;
      rxf_reg    <= rxf_next;
      txt_reg    <= txt_next;
      addr_reg   <= cfg_addr;   // programmable address
    end
  end

  assign rx_data  = rxd_reg;
  assign rx_valid = rxv_reg;
  assign rx_first = rxf_reg;
  assign tx_taken = txt_reg;

  // ---------------- general pins ----------------
  logic [NP-1:0] sel_reg, sel_next, pad_in;
  logic [NP-1:0] p1_reg, p2_reg, gin_reg, sin_reg, po_reg, poe_reg;

  function automatic int ones(input logic [NP-1:0] v);
    int n;
    n = 0;
    for (int i = 0; i < NP; i++) begin
      n = n + int'(v[i]);
    end
    return n;
  endfunction

  // selection limit
  // a request naming too many pins is refused and the old set kept
  always_comb begin
    sel_next = (ones(pin_sel) <= USABLE) ? pin_sel : sel_reg;
  end

  always_ff @(posedge clk or posedge rc2_reg) begin
    if (rc2_reg) begin
      sel_reg <= '0;
    end else begin
      sel_reg <= sel_next;
    end
  end

  assign pad_in = {general_port_one_i, general_port_zero_i};

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_pin
      always_ff @(posedge clk or posedge rc2_reg) begin
        if (rc2_reg) begin
          p1_reg[g]  <= 1'b0;
          p2_reg[g]  <= 1'b0;
          gin_reg[g] <= 1'b0;
          sin_reg[g] <= 1'b0;
          po_reg[g]  <= 1'b0;
          poe_reg[g] <= 1'b1;
        end else begin
          p1_reg[g]  <= pad_in[g];
          p2_reg[g]  <= p1_reg[g];
          gin_reg[g] <= sel_reg[g] & ~pin_sense[g] & p2_reg[g];
          sin_reg[g] <= sel_reg[g] & pin_sense[g] & p2_reg[g];
          po_reg[g]  <= gpio_out[g];
          poe_reg[g] <= ~(sel_reg[g] & ~pin_sense[g] & gpio_dir[g]);
        end
      end
    end
  endgenerate

  assign gpio_in                = gin_reg;
  assign sense_in               = sin_reg;
  assign general_port_zero_o    = po_reg[4:0];
  assign general_port_zero_oe_n = poe_reg[4:0];
  assign general_port_one_o     = po_reg[9:5];
  assign general_port_one_oe_n  = poe_reg[9:5];
endmodule // tce_device

/* File: hw/tce_defs.svh */
`ifndef TCE_DEFS_SVH
`define TCE_DEFS_SVH

// core clock period and the fixed acknowledge delay a non-stretching master waits
`define TCE_CLK_NS        50
`define TCE_ACK_TIME_NS   100000
`define TCE_ACK_CYC       ((`TCE_ACK_TIME_NS + `TCE_CLK_NS - 1) / `TCE_CLK_NS)

// bus bit period made by the master divider (400 kbit/s)
`define TCE_SCL_PERIOD_NS 2500
`define TCE_SCL_HALF_CYC  (`TCE_SCL_PERIOD_NS / 2 / `TCE_CLK_NS)

// core cycles spent on each received byte while the clock is held
`define TCE_PROC_CYC      64

// general pins: two ports of five, of which a variant may use fewer
`define TCE_PORT_PINS     5
`define TCE_PIN_COUNT     10
`define TCE_USABLE_PINS   8

`endif

/* File: hw/tce_pkg.sv */
package tce_pkg;

  // meaning of the byte handed from the link to the core
  typedef enum logic [1:0] {TCE_K_ADDR, TCE_K_WR, TCE_K_RD} tce_kind_e;

  // device link states
  typedef enum logic [2:0] {
    L_IDLE, L_RX, L_WAIT, L_ACK, L_TX, L_MACK, L_SKIP
  } tce_lnk_e;

  // master states
  typedef enum logic [2:0] {
    H_IDLE, H_CHECK, H_START, H_LOW, H_HIGH, H_STOP1, H_STOP2
  } tce_hst_e;

endpackage

/* File: hw/tce_if.sv */
`timescale 1ns/1ps
interface tce_if;
  logic scl;
  logic sda;
  logic dev_scl_o;
  logic dev_scl_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;

  // wired-and with pull-ups: a released pin reads high
  assign scl = (dev_scl_oe_n | dev_scl_o) & (host_scl_oe_n | host_scl_o);
  assign sda = (dev_sda_oe_n | dev_sda_o) & (host_sda_oe_n | host_sda_o);

  modport dev (
    input  scl, sda,
    output dev_scl_o, dev_scl_oe_n, dev_sda_o, dev_sda_oe_n
  );
  modport host (
    input  scl, sda,
    output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n
  );
endinterface // tce_if

/* File: hw/tce_host.sv */
`timescale 1ns/1ps
`include "tce_defs.svh"
module tce_host
  import tce_pkg::*;
#(
  parameter int HALF    = `TCE_SCL_HALF_CYC,
  parameter int ACK_CYC = `TCE_ACK_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  tce_if.host             bus,
  input  wire logic       stretch_en,
  input  wire logic       req,
  input  wire logic [6:0] req_addr,
  input  wire logic       req_rd,
  input  wire logic [7:0] req_len,
  input  wire logic [7:0] wr_data,
  output logic            wr_taken,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            busy,
  output logic            done,
  output logic            nack
);
  tce_hst_e   st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next, lowlen;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] idx_reg, idx_next, len_reg, len_next, sh_reg, sh_next;
  logic [7:0] rdd_reg, rdd_next;
  logic       rd_reg, rd_next, sclo_reg, sclo_next, sdao_reg, sdao_next;
  logic       busy_reg, busy_next, done_reg, done_next, nack_reg, nack_next;
  logic       rdv_reg, rdv_next, wrt_reg, wrt_next;
  logic       scl1_reg, scl2_reg, sda1_reg, sda2_reg;
  logic       wr_ph, last, dbit;

  assign wr_ph = (idx_reg == 8'h00) | ~rd_reg;
  assign last  = (idx_reg == len_reg);
  // line level wanted in this bit; the open-drain enable follows it
  assign dbit  = bit_reg[3] ? (wr_ph | last) : (~wr_ph | sh_reg[7]);
  // fixed wait before the ack bit
  // later read bytes are fetched after our ack, so their first bit waits too
  assign lowlen = (!stretch_en && (bit_reg[3] ||
                   (bit_reg == 4'h0 && !wr_ph && idx_reg > 8'h01))) ? 16'(ACK_CYC) : 16'(HALF);

  // master sequencer, bus clock made by dividing clk
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    bit_next  = bit_reg;
    idx_next  = idx_reg;
    len_next  = len_reg;
    sh_next   = sh_reg;
    rdd_next  = rdd_reg;
    rd_next   = rd_reg;
    sclo_next = sclo_reg;
    sdao_next = sdao_reg;
    busy_next = busy_reg;
    nack_next = nack_reg;
    done_next = 1'b0;
    rdv_next  = 1'b0;
    wrt_next  = 1'b0;
    case (st_reg)
      H_IDLE: begin
        if (req) begin
          // address byte first, direction in lsb
          sh_next   = {req_addr, req_rd};
          rd_next   = req_rd;
          len_next  = req_len;
          busy_next = 1'b1;
          nack_next = 1'b0;
          cnt_next  = 16'h0000;
          st_next   = H_CHECK;
        end
      end
      H_CHECK: begin
        if (scl2_reg && sda2_reg) begin
          sdao_next = 1'b0;
          st_next   = H_START;
        end
      end
      H_START: begin
        if (cnt_reg == 16'(HALF - 1)) begin
          sclo_next = 1'b0;
          cnt_next  = 16'h0000;
          bit_next  = 4'h0;
          idx_next  = 8'h00;
          st_next   = H_LOW;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      H_LOW: begin
        sdao_next = dbit;
        if (cnt_reg >= lowlen - 16'h0001) begin
          sclo_next = 1'b1;
          cnt_next  = 16'h0000;
          st_next   = H_HIGH;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      H_HIGH: begin
        // wait while the device holds the clock
        if (stretch_en && !scl2_reg) begin
          cnt_next = 16'h0000;
        end else if (cnt_reg == 16'(HALF - 1)) begin
          cnt_next  = 16'h0000;
          sclo_next = 1'b0;
          st_next   = H_LOW;
          if (!bit_reg[3]) begin
            sh_next  = {sh_reg[6:0], sda2_reg};
            bit_next = bit_reg + 4'h1;
          end else begin
            bit_next = 4'h0;
            idx_next = idx_reg + 8'h01;
            if (wr_ph) begin
              if (sda2_reg) begin
                nack_next = 1'b1;
                st_next   = H_STOP1;
              end else if (last) begin
                st_next = H_STOP1;
              end else if (!rd_reg) begin
                sh_next  = wr_data;
                wrt_next = 1'b1;
              end
            end else begin
              rdd_next = sh_reg;
              rdv_next = 1'b1;
              if (last) begin
                st_next = H_STOP1;
              end
            end
          end
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      H_STOP1: begin
        sdao_next = 1'b0;
        if (cnt_reg == 16'(HALF - 1)) begin
          sclo_next = 1'b1;
          cnt_next  = 16'h0000;
          st_next   = H_STOP2;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      H_STOP2: begin
        if (!scl2_reg) begin
          cnt_next = 16'h0000;
        end else if (cnt_reg == 16'(HALF - 1)) begin
          sdao_next = 1'b1;
          busy_next = 1'b0;
          done_next = 1'b1;
          st_next   = H_IDLE;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      default: begin
        st_next = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg   <= H_IDLE;
      cnt_reg  <= 16'h0000;
      bit_reg  <= 4'h0;
      idx_reg  <= 8'h00;
      len_reg  <= 8'h00;
      sh_reg   <= 8'h00;
      rdd_reg  <= 8'h00;
      rd_reg   <= 1'b0;
      sclo_reg <= 1'b1;
      sdao_reg <= 1'b1;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
      rdv_reg  <= 1'b0;
      wrt_reg  <= 1'b0;
      scl1_reg <= 1'b1;
      scl2_reg <= 1'b1;
      sda1_reg <= 1'b1;
      sda2_reg <= 1'b1;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      bit_reg  <= bit_next;
      idx_reg  <= idx_next;
      len_reg  <= len_next;
      sh_reg   <= sh_next;
      rdd_reg  <= rdd_next;
      rd_reg   <= rd_next;
      sclo_reg <= sclo_next;
      sdao_reg <= sdao_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      nack_reg <= nack_next;
      rdv_reg  <= rdv_next;
      wrt_reg  <= wrt_next;
      scl1_reg <= bus.scl;
      scl2_reg <= scl1_reg;
      sda1_reg <= bus.sda;
      sda2_reg <= sda1_reg;
    end
  end

  assign bus.host_scl_o    = 1'b0;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_scl_oe_n = sclo_reg;
  assign bus.host_sda_oe_n = sdao_reg;
  assign wr_taken = wrt_reg;
  assign rd_data  = rdd_reg;
  assign rd_valid = rdv_reg;
  assign busy     = busy_reg;
  assign done     = done_reg;
  assign nack     = nack_reg;
endmodule // tce_host

/* File: testbench/tce_props.sv */
`timescale 1ns/1ps
module tce_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic rx_valid,
  input wire logic tx_taken,
  input wire logic busy,
  input wire logic done,
  input wire logic nack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // a stretch covers the byte work, but must end
  AST_HOLD_MIN: assert property ($fell(dev_scl_oe_n) |=> !dev_scl_oe_n [*3])
    else $error("clock stretch too short");
  AST_HOLD_MAX: assert property ($fell(dev_scl_oe_n) |-> ##[1:300] $rose(dev_scl_oe_n))
    else $error("clock stretch never ends");
  AST_HOLD_LOW: assert property ($fell(dev_scl_oe_n) |-> !$past(scl))
    else $error("stretch began with clock high");
  AST_RX_HELD: assert property (rx_valid |-> !dev_scl_oe_n)
    else $error("byte reported after clock release");
  AST_TX_HELD: assert property (tx_taken |-> !dev_scl_oe_n)
    else $error("read byte taken without stretch");
  // data may only move while the clock is low, else a false start or stop
  AST_SDA_CHG: assert property ($changed(dev_sda_oe_n) |-> !$past(scl))
    else $error("device data moved with clock high");
  AST_IDLE_QUIET: assert property (!busy |-> dev_scl_oe_n && dev_sda_oe_n)
    else $error("device drives an idle bus");
  AST_DONE_IDLE: assert property (done |-> scl && sda)
    else $error("bus not free after stop");
  cover property (rx_valid);
  cover property (tx_taken);
  cover property ($rose(nack));
endmodule // tce_props

/* File: testbench/tce_bench.sv */
`timescale 1ns/1ps
module tce_bench;
  logic       clk, rst, link_clk, ext_rst, stretch_en, req, req_rd, fst;
  logic       wr_taken, rd_valid, busy, done, nack, rx_valid, rx_first, tx_taken;
  logic [6:0] cfg_addr, req_addr;
  logic [7:0] req_len, wr_data, rd_data, rx_data, tx_data;
  logic [9:0] pin_sel, pin_sense, gpio_dir, gpio_out, gpio_in, sense_in, pads;
  wire  [9:0] oe_n, pout;
  int         n_fail, tests_run, seed, cyc;
  int         wq[$], eq[$], rq[$];
  tce_if bus_if ();
  tce_device #(.PROC_CYC(4)) tce_device_i (.clk(clk), .rst(rst), .link_clk(link_clk),
    .external_reset_pin(ext_rst), .bus(bus_if), .cfg_addr(cfg_addr), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_first(rx_first), .tx_data(tx_data), .tx_taken(tx_taken),
    .pin_sel(pin_sel), .pin_sense(pin_sense), .gpio_dir(gpio_dir), .gpio_out(gpio_out),
    .gpio_in(gpio_in), .sense_in(sense_in), .general_port_zero_i(pads[4:0]),
    .general_port_zero_o(pout[4:0]), .general_port_zero_oe_n(oe_n[4:0]),
    .general_port_one_i(pads[9:5]), .general_port_one_o(pout[9:5]),
    .general_port_one_oe_n(oe_n[9:5]));
  tce_host #(.HALF(8), .ACK_CYC(200)) tce_host_i (.clk(clk), .rst(rst), .bus(bus_if),
    .stretch_en(stretch_en), .req(req), .req_addr(req_addr), .req_rd(req_rd),
    .req_len(req_len), .wr_data(wr_data), .wr_taken(wr_taken), .rd_data(rd_data),
    .rd_valid(rd_valid), .busy(busy), .done(done), .nack(nack));
  tce_props tce_props_i (.clk(clk), .rst(rst), .scl(bus_if.scl), .sda(bus_if.sda),
    .dev_scl_oe_n(bus_if.dev_scl_oe_n), .dev_sda_oe_n(bus_if.dev_sda_oe_n),
    .rx_valid(rx_valid), .tx_taken(tx_taken), .busy(busy), .done(done), .nack(nack));
  // link clock unrelated in phase to the core clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // byte model; sampled at the falling edge where one-cycle pulses are settled
  always @(negedge clk) begin
    cyc++;
    if (rx_valid === 1'b1) begin
      chk("rx_first", {9'h0, fst}, {9'h0, rx_first});
      fst = 1'b0;
      chk("rx_data", 10'(eq.size() ? eq.pop_front() : 1023), {2'h0, rx_data});
    end
    if (tx_taken === 1'b1) begin
      rq.push_back(int'(tx_data));
      tx_data <= 8'($random(seed));
    end
    if (rd_valid === 1'b1) begin
      chk("rd_data", 10'(rq.size() ? rq.pop_front() : 1023), {2'h0, rd_data});
    end
    if (wr_taken === 1'b1 && wq.size() > 0) begin
      void'(wq.pop_front());
      wr_data <= 8'(wq.size() ? wq[0] : 0);
    end
    // hang guard, far beyond the whole sequence
    if (cyc > 40000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic xfer(input logic [6:0] a, input logic rd, input int len, input logic se);
    int i;
    wq.delete();
    for (i = 0; i < len; i++) begin
      wq.push_back($random(seed) & 255);
      if (!rd && a == cfg_addr) eq.push_back(wq[i]);
    end
    @(negedge clk);
    wr_data <= 8'(wq.size() ? wq[0] : 0);
    {req_addr, req_rd, req_len, stretch_en, req} <= {a, rd, 8'(len), se, 1'b1};
    fst = 1'b1;
    @(negedge clk);
    req <= 1'b0;
    for (i = 0; i < 20000 && done !== 1'b1; i++) @(negedge clk);
    chk("done", 10'h1, {9'h0, done});
    chk("nack", {9'h0, a != cfg_addr}, {9'h0, nack});
    chk("left", 10'h0, 10'(eq.size() + rq.size()));
    $display("xfer %h rd %0d len %0d ended", a, rd, len);
  endtask
  // unselected pins must read zero and never drive
  task automatic pin_check(input logic [9:0] s);
    logic [9:0] g;
    g = s & ~pin_sense;
    chk("pad_oe_n", ~(g & gpio_dir), oe_n);
    chk("pad_o", g & gpio_dir & gpio_out, g & gpio_dir & pout);
    chk("gpio_in", pads & g & ~gpio_dir, gpio_in & (~s | (g & ~gpio_dir)));
    chk("sense_in", pads & s & pin_sense, sense_in & (~s | pin_sense));
  endtask
  initial begin
    {rst, ext_rst, stretch_en, req, req_rd, req_addr, req_len, wr_data} = '0;
    {pin_sel, pin_sense, gpio_dir, gpio_out} = '0;
    rst = 1'b1;
    seed = 32'hE700;
    cfg_addr = 7'($random(seed));
    tx_data = 8'($random(seed));
    pads = 10'($random(seed));
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst <= 1'b0;
    repeat (10) @(negedge clk);
    xfer(cfg_addr, 1'b0, 3, 1'b1);
    xfer(cfg_addr, 1'b1, 3, 1'b1);
    xfer(cfg_addr ^ 7'h01, 1'b0, 2, 1'b1);
    xfer(cfg_addr ^ 7'h40, 1'b1, 1, 1'b1);
    xfer(cfg_addr, 1'b0, 0, 1'b1);
    cfg_addr = 7'h4B;
    xfer(7'h4B, 1'b0, 2, 1'b0);
    xfer(7'h4B, 1'b1, 2, 1'b0);
    {pin_sense, gpio_dir, gpio_out} <= {10'($random(seed)), 10'($random(seed)), 10'($random(seed))};
    pin_sel <= 10'h3FC;
    repeat (8) @(negedge clk);
    pin_check(10'h3FC);
    pin_sel <= 10'h3FE;
    repeat (8) @(negedge clk);
    pin_check(10'h3FC);
    $display("pin test ended");
    ext_rst <= 1'b1;
    repeat (4) @(negedge clk);
    chk("external_reset_pin_oe_n", 10'h3FF, oe_n);
    ext_rst <= 1'b0;
    repeat (10) @(negedge clk);
    xfer(7'h4B, 1'b0, 1, 1'b1);
    stop_test();
  end
endmodule // tce_bench
